/* File: core/cache_hidden_mgmt_memory_pkg.sv */
// Constants for the cache mode and hidden management memory block.
// Assumes APB byte addresses equal four times the setup control index.
package cache_hidden_mgmt_memory_pkg;

	// Setup control indexes (byte address is index times four)
	localparam logic [7:0]  IDX_SMM_ATTR       = 8'h11;
	localparam logic [7:0]  IDX_CACHE_MISC     = 8'h14;
	localparam logic [7:0]  IDX_XMI_CTRL       = 8'h9d;
	localparam logic [7:0]  IDX_CR0_IMAGE      = 8'he0;
	localparam logic [7:0]  IDX_BASE_PTR       = 8'he1;
	localparam logic [7:0]  IDX_EVT_STATUS     = 8'he2;
	localparam logic [7:0]  IDX_MODE_STATUS    = 8'he3;

	// Field positions
	localparam int          WB_SEL_BIT         = 0;
	localparam int          FLUSH_SUPPRESS_BIT = 5;
	localparam int          SMM_CACHE_EN_BIT   = 6;
	localparam int          MASTER_EN_BIT      = 0;
	localparam int          CACHE_DIS_POS      = 30;
	localparam int          NO_WT_POS          = 29;
	localparam int          EVT_PMU_BIT        = 0;
	localparam int          EVT_KBD_BIT        = 1;

	// Reset values
	localparam logic        WB_SEL_RESET       = 1'b0;
	localparam logic [1:0]  SMM_ATTR_RESET     = 2'b00;
	localparam logic        MASTER_EN_RESET    = 1'b0;
	localparam logic [1:0]  CR0_CACHE_RESET    = 2'b00;
	localparam logic [31:0] BASE_PTR_RESET     = 32'h0003_0000;

	// Management memory layout, offsets from the base pointer
	localparam logic [31:0] HIDDEN_MGMT_MEMORY_IMPL_OFS     = 32'h0000_8000;
	localparam logic [31:0] SAVE_AREA_OFS      = 32'h0000_fe00;
	localparam logic [31:0] HIDDEN_MGMT_MEMORY_END_OFS      = 32'h0000_ffff;
	localparam logic [31:0] BASE_ALIGN_MASK    = 32'hffff_8000;
	localparam logic [15:0] GP_ERROR_CODE      = 16'h0000;

	typedef enum logic [1:0] {
		MM_IDLE   = 2'b00,
		MM_FLUSH  = 2'b01,
		MM_ENTER  = 2'b10,
		MM_ACTIVE = 2'b11
	} mgmt_state_t;

endpackage : cache_hidden_mgmt_memory_pkg

/* File: core/hidden_mgmt_memory_window_decode.sv */
// Decodes an address against the relocatable hidden management memory.
// Assumes the base pointer is aligned to 32 Kbytes.
`timescale 1ns/1ps
`default_nettype none

module hidden_mgmt_memory_window_decode
	import cache_hidden_mgmt_memory_pkg::*;
(
	input  wire logic [31:0] base_ptr,
	input  wire logic [31:0] addr,
	output logic             in_window,
	output logic             in_save_area,
	output logic [14:0]      offset
);

	logic [31:0] rel;

	// Offset from the current base pointer
	always_comb begin
		rel          = addr - base_ptr;
		in_window    = (rel >= HIDDEN_MGMT_MEMORY_IMPL_OFS) && (rel <= HIDDEN_MGMT_MEMORY_END_OFS);
		in_save_area = (rel >= SAVE_AREA_OFS) && (rel <= HIDDEN_MGMT_MEMORY_END_OFS);
		offset       = rel[14:0];
	end

endmodule : hidden_mgmt_memory_window_decode

`default_nettype wire

/* File: core/cache_mode_hidden_mgmt_memory_map.sv */
// Cache mode control and hidden management memory map with APB registers.
// Assumes sources, core and cache logic on clk; APB master per protocol.
//
// The APB slave port and the register addresses were decided locally.
`timescale 1ns/1ps
`default_nettype none

module cache_mode_hidden_mgmt_memory_map
	import cache_hidden_mgmt_memory_pkg::*;
#(
	parameter int CACHE_BYTES = 8192
) (
	input  wire logic        clk,
	input  wire logic        reset,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	// Control register writes from the core
	input  wire logic        cr0_wr,
	input  wire logic [31:0] cr0_wr_data,
	output logic             gp_fault,
	output logic [15:0]      gp_error_code,
	// Cache controls
	output logic             line_fill_en,
	output logic             write_through_en,
	output logic             invalidate_en,
	output logic             cache_flush_req,
	input  wire logic        cache_flush_done,
	// Per-access lookup
	input  wire logic        acc_valid,
	input  wire logic [31:0] acc_addr,
	input  wire logic        acc_isa,
	input  wire logic        acc_noncache,
	input  wire logic        acc_dma,
	output logic             acc_done,
	output logic             acc_cacheable,
	output logic             acc_write_back,
	output logic             acc_to_hidden_mgmt_memory,
	output logic             acc_save_area,
	output logic [14:0]      acc_hidden_mgmt_memory_offset,
	// Management interrupt sources and core
	input  wire logic        pmu_mgmt_req,
	input  wire logic        kbd_mgmt_req,
	input  wire logic        rsm_exec,
	output logic             mgmt_interrupt,
	output logic             mgmt_mode,
	output logic [31:0]      handler_entry_addr
);

	logic        wb_sel_r;
	logic [1:0]  smm_attr_r;
	logic        master_en_r;
	logic        cache_disable_bit_r;
	logic        no_write_through_bit_r;
	logic [31:0] mgmt_memory_base_pointer_r;
	logic [1:0]  evt_pend_r;
	logic [7:0]  fault_cnt_r;
	mgmt_state_t state_r;
	mgmt_state_t state_nxt;
	logic [7:0]  idx;
	logic        wr_en;
	logic        rd_setup;
	logic        mapped;
	logic [31:0] rd_val;
	logic        win_hit;
	logic        win_save;
	logic [14:0] win_ofs;
	logic        int_pending;
	logic        bad_combo;

	// Valid cache-bit combination check
	function automatic logic combo_ok(input logic cd, input logic nw);
		combo_ok = !(!cd && nw);
	endfunction : combo_ok

	// Index decode from a byte address
	function automatic logic [7:0] reg_index(input logic [11:0] a);
		reg_index = a[9:2];
	endfunction : reg_index

	function automatic logic idx_mapped(input logic [7:0] i);
		case (i)
			IDX_SMM_ATTR, IDX_CACHE_MISC, IDX_XMI_CTRL, IDX_CR0_IMAGE,
			IDX_BASE_PTR, IDX_EVT_STATUS, IDX_MODE_STATUS: idx_mapped = 1'b1;
			default: idx_mapped = 1'b0;
		endcase
	endfunction : idx_mapped

	// APB decode, zero wait states
	assign idx      = reg_index(paddr);
	assign mapped   = idx_mapped(idx) && (paddr[11:10] == 2'b00) && (paddr[1:0] == 2'b00);
	assign wr_en    = psel && penable && pwrite && mapped;
	assign rd_setup = psel && !penable && !pwrite;
	assign pready   = psel && penable;
	assign pslverr  = psel && penable && !mapped;

	always_comb begin
		rd_val = 32'h0000_0000;
		case (idx)
			IDX_SMM_ATTR: begin
				rd_val[FLUSH_SUPPRESS_BIT] = smm_attr_r[0];
				rd_val[SMM_CACHE_EN_BIT]   = smm_attr_r[1];
			end
			IDX_CACHE_MISC:  rd_val[WB_SEL_BIT] = wb_sel_r;
			IDX_XMI_CTRL:    rd_val[MASTER_EN_BIT] = master_en_r;
			IDX_CR0_IMAGE: begin
				rd_val[CACHE_DIS_POS] = cache_disable_bit_r;
				rd_val[NO_WT_POS]     = no_write_through_bit_r;
			end
			IDX_BASE_PTR:    rd_val = mgmt_memory_base_pointer_r;
			IDX_EVT_STATUS:  rd_val[1:0] = evt_pend_r;
			IDX_MODE_STATUS: rd_val = {fault_cnt_r, 22'h000000, state_r};
			default:         rd_val = 32'h0000_0000;
		endcase
	end

	// Read data captured in the setup cycle
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			prdata <= 32'h0000_0000;
		end else if (rd_setup) begin
			prdata <= mapped ? rd_val : 32'h0000_0000;
		end
	end

	// Write-through by default, write-back on request
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			wb_sel_r <= WB_SEL_RESET;
		end else if (wr_en && idx == IDX_CACHE_MISC) begin
			wb_sel_r <= pwdata[WB_SEL_BIT];
		end
	end

	// Flush suppress and cache-in-management-mode bits
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			smm_attr_r <= SMM_ATTR_RESET;
		end else if (wr_en && idx == IDX_SMM_ATTR) begin
			smm_attr_r <= {pwdata[SMM_CACHE_EN_BIT], pwdata[FLUSH_SUPPRESS_BIT]};
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			master_en_r <= MASTER_EN_RESET;
		end else if (wr_en && idx == IDX_XMI_CTRL) begin
			master_en_r <= pwdata[MASTER_EN_BIT];
		end
	end

	// Base pointer kept aligned to 32 Kbytes
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			mgmt_memory_base_pointer_r <= BASE_PTR_RESET;
		end else if (wr_en && idx == IDX_BASE_PTR) begin
			mgmt_memory_base_pointer_r <= pwdata & BASE_ALIGN_MASK;
		end
	end

	// Disable clear with no-write-through set is refused
	assign bad_combo = cr0_wr && !combo_ok(cr0_wr_data[CACHE_DIS_POS], cr0_wr_data[NO_WT_POS]);

	// Control register cache bits with invalid combination fault
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			cache_disable_bit_r    <= CR0_CACHE_RESET[1];
			no_write_through_bit_r <= CR0_CACHE_RESET[0];
		end else if (cr0_wr && !bad_combo) begin
			cache_disable_bit_r    <= cr0_wr_data[CACHE_DIS_POS];
			no_write_through_bit_r <= cr0_wr_data[NO_WT_POS];
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			gp_fault      <= 1'b0;
			gp_error_code <= GP_ERROR_CODE;
		end else begin
			gp_fault      <= bad_combo;
			gp_error_code <= GP_ERROR_CODE;
		end
	end

	// Count of refused control writes
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			fault_cnt_r <= 8'h00;
		end else if (bad_combo) begin
			fault_cnt_r <= fault_cnt_r + 8'h01;
		end
	end

	// Cache operation enables from the decoded mode
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			line_fill_en     <= 1'b0;
			write_through_en <= 1'b0;
			invalidate_en    <= 1'b0;
		end else begin
			case ({cache_disable_bit_r, no_write_through_bit_r})
				2'b11: begin
					line_fill_en     <= 1'b0;
					write_through_en <= 1'b0;
					invalidate_en    <= 1'b0;
				end
				2'b10: begin
					line_fill_en     <= 1'b0;
					write_through_en <= 1'b1;
					invalidate_en    <= 1'b1;
				end
				default: begin
					line_fill_en     <= 1'b1;
					write_through_en <= 1'b1;
					invalidate_en    <= 1'b1;
				end
			endcase
		end
	end

	hidden_mgmt_memory_window_decode u_window (
		.base_ptr     (mgmt_memory_base_pointer_r),
		.addr         (acc_addr),
		.in_window    (win_hit),
		.in_save_area (win_save),
		.offset       (win_ofs)
	);

	// Per-access cacheability and management memory steering
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			acc_done         <= 1'b0;
			acc_cacheable    <= 1'b0;
			acc_write_back   <= 1'b0;
			acc_to_hidden_mgmt_memory     <= 1'b0;
			acc_save_area    <= 1'b0;
			acc_hidden_mgmt_memory_offset <= 15'h0000;
		end else begin
			acc_done         <= acc_valid;
			acc_cacheable    <= acc_valid && !acc_isa && !acc_noncache && !cache_disable_bit_r
				&& !(mgmt_mode && !smm_attr_r[1]);
			acc_write_back   <= acc_valid && !acc_isa && !acc_noncache && wb_sel_r;
			acc_to_hidden_mgmt_memory     <= acc_valid && mgmt_mode && !acc_dma && win_hit;
			acc_save_area    <= acc_valid && mgmt_mode && !acc_dma && win_save;
			acc_hidden_mgmt_memory_offset <= win_ofs;
		end
	end

	// Sticky interrupt sources; a new request beats a clear
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			evt_pend_r <= 2'b00;
		end else begin
			for (int i = 0; i < 2; i++) begin
				if (wr_en && idx == IDX_EVT_STATUS && pwdata[i]) begin
					evt_pend_r[i] <= 1'b0;
				end
			end
			if (pmu_mgmt_req) begin
				evt_pend_r[EVT_PMU_BIT] <= 1'b1;
			end
			if (kbd_mgmt_req) begin
				evt_pend_r[EVT_KBD_BIT] <= 1'b1;
			end
		end
	end

	assign int_pending = (|evt_pend_r) && master_en_r;

	// Management mode sequencing
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			MM_IDLE: begin
				if (int_pending) begin
					state_nxt = smm_attr_r[0] ? MM_ENTER : MM_FLUSH;
				end
			end
			MM_FLUSH: begin
				if (cache_flush_done) begin
					state_nxt = MM_ENTER;
				end
			end
			MM_ENTER:  state_nxt = MM_ACTIVE;
			MM_ACTIVE: begin
				if (rsm_exec) begin
					state_nxt = MM_IDLE;
				end
			end
			default:   state_nxt = MM_IDLE;
		endcase
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			state_r <= MM_IDLE;
		end else begin
			state_r <= state_nxt;
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			mgmt_interrupt  <= 1'b0;
			mgmt_mode       <= 1'b0;
			cache_flush_req <= 1'b0;
		end else begin
			mgmt_interrupt  <= (state_nxt == MM_ENTER);
			mgmt_mode       <= (state_nxt == MM_ENTER) || (state_nxt == MM_ACTIVE);
			cache_flush_req <= (state_nxt == MM_FLUSH);
		end
	end

	// Handler entry follows the base pointer
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			handler_entry_addr <= 32'h0000_0000;
		end else begin
			handler_entry_addr <= mgmt_memory_base_pointer_r + HIDDEN_MGMT_MEMORY_IMPL_OFS;
		end
	end

endmodule : cache_mode_hidden_mgmt_memory_map

`default_nettype wire

/* File: testbench/cache_hidden_mgmt_memory_sva.sv */
// Port assertions for the cache mode and management memory map block.
// Assumes one clock domain; bound to every instance of the block.
`timescale 1ns/1ps
`default_nettype none
module cache_hidden_mgmt_memory_sva
	import cache_hidden_mgmt_memory_pkg::*;
(
	input wire logic        clk,
	input wire logic        reset,
	input wire logic        cr0_wr,
	input wire logic [31:0] cr0_wr_data,
	input wire logic        gp_fault,
	input wire logic [15:0] gp_error_code,
	input wire logic        line_fill_en,
	input wire logic        write_through_en,
	input wire logic        invalidate_en,
	input wire logic        cache_flush_req,
	input wire logic        cache_flush_done,
	input wire logic        acc_valid,
	input wire logic [31:0] acc_addr,
	input wire logic        acc_isa,
	input wire logic        acc_dma,
	input wire logic        acc_done,
	input wire logic        acc_cacheable,
	input wire logic        acc_to_hidden_mgmt_memory,
	input wire logic        acc_save_area,
	input wire logic [14:0] acc_hidden_mgmt_memory_offset,
	input wire logic        rsm_exec,
	input wire logic        mgmt_interrupt,
	input wire logic        mgmt_mode,
	input wire logic [31:0] handler_entry_addr
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);
	logic bad_w;
	logic cd_w;
	logic nw_w;
	logic mm_w;
	assign cd_w = cr0_wr && cr0_wr_data[CACHE_DIS_POS];
	assign nw_w = cr0_wr_data[NO_WT_POS];
	assign bad_w = cr0_wr && !cr0_wr_data[CACHE_DIS_POS] && nw_w;
	assign mm_w = acc_valid && mgmt_mode && !acc_dma;
	chk_fault_pulse: assert property (bad_w |=> gp_fault && gp_error_code == 16'h0000)
		else $error("invalid cache bits gave no fault");
	chk_full_off: assert property (cd_w && nw_w |-> ##2 !line_fill_en && !write_through_en && !invalidate_en)
		else $error("cache not fully blocked");
	chk_fill_off: assert property (cd_w && !nw_w |-> ##2 !line_fill_en && write_through_en && invalidate_en)
		else $error("fill-only block wrong");
	chk_all_on: assert property (cr0_wr && !cr0_wr_data[CACHE_DIS_POS] && !nw_w |-> ##2 line_fill_en && write_through_en && invalidate_en)
		else $error("normal mode not enabled");
	chk_mode_kept: assert property (bad_w |-> ##2 $stable(line_fill_en) && $stable(write_through_en) && $stable(invalidate_en))
		else $error("faulting write changed mode");
	chk_isa_uncached: assert property (acc_valid && acc_isa |=> acc_done && !acc_cacheable)
		else $error("bus access cached");
	chk_entry_map: assert property (mm_w && acc_addr == handler_entry_addr |=> acc_to_hidden_mgmt_memory && !acc_save_area && acc_hidden_mgmt_memory_offset == 15'h0000)
		else $error("entry point not first location");
	chk_save_map: assert property (mm_w && acc_addr == handler_entry_addr + 32'h0000_7e00 |=> acc_to_hidden_mgmt_memory && acc_save_area && acc_hidden_mgmt_memory_offset == 15'h7e00)
		else $error("save area start wrong");
	chk_resume_exit: assert property (mgmt_mode && rsm_exec |=> !mgmt_mode)
		else $error("resume did not leave mode");
	chk_entry_pulse: assert property ($rose(mgmt_mode) |-> mgmt_interrupt)
		else $error("mode entered without interrupt");
	chk_flush_end: assert property (cache_flush_req && cache_flush_done |-> ##[1:2] mgmt_interrupt)
		else $error("entry missing after flush");
	cover property (bad_w);
	cover property (mgmt_interrupt);
	cover property (cache_flush_req && cache_flush_done);
endmodule : cache_hidden_mgmt_memory_sva
bind cache_mode_hidden_mgmt_memory_map cache_hidden_mgmt_memory_sva u_sva (.clk, .reset, .cr0_wr, .cr0_wr_data, .gp_fault,
	.gp_error_code, .line_fill_en, .write_through_en, .invalidate_en, .cache_flush_req,
	.cache_flush_done, .acc_valid, .acc_addr, .acc_isa, .acc_dma, .acc_done, .acc_cacheable,
	.acc_to_hidden_mgmt_memory, .acc_save_area, .acc_hidden_mgmt_memory_offset, .rsm_exec, .mgmt_interrupt, .mgmt_mode,
	.handler_entry_addr);
`default_nettype wire

/* File: testbench/flush_partner.sv */
// Cache model answering flush requests promptly or slowly.
// Assumes the request is held until the done pulse is seen.
`timescale 1ns/1ps
`default_nettype none
module flush_partner (
	input  wire logic clk,
	input  wire logic reset,
	input  wire logic slow,
	input  wire logic cache_flush_req,
	output logic      cache_flush_done
);
	logic [3:0] wait_r;
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			wait_r <= 4'h0;
			cache_flush_done <= 1'b0;
		end else if (cache_flush_req && !cache_flush_done) begin
			wait_r <= wait_r + 4'h1;
			cache_flush_done <= (wait_r >= (slow ? 4'h6 : 4'h0));
		end else begin
			wait_r <= 4'h0;
			cache_flush_done <= 1'b0;
		end
	end
endmodule : flush_partner
`default_nettype wire

/* File: testbench/cache_mode_hidden_mgmt_memory_map_bench.sv */
// Self-checking bench for the cache mode and management memory map.
// Assumes APB byte address is four times the index; flush partner attached.
`timescale 1ns/1ps
`default_nettype none
module cache_mode_hidden_mgmt_memory_map_bench;
	import cache_hidden_mgmt_memory_pkg::*;
	logic        clk, reset, psel, penable, pwrite, cr0_wr, acc_valid, acc_isa, acc_noncache;
	logic        acc_dma, pmu_mgmt_req, kbd_mgmt_req, rsm_exec, slow, err;
	logic [11:0] paddr;
	logic [31:0] pwdata, cr0_wr_data, acc_addr, rd, prdata, handler_entry_addr;
	logic        pready, pslverr, gp_fault, line_fill_en, write_through_en, invalidate_en;
	logic        cache_flush_req, cache_flush_done, acc_done, acc_cacheable, acc_write_back;
	logic        acc_to_hidden_mgmt_memory, acc_save_area, mgmt_interrupt, mgmt_mode;
	logic [15:0] gp_error_code;
	logic [14:0] acc_hidden_mgmt_memory_offset;
	int          bad_count, checked;
	cache_mode_hidden_mgmt_memory_map #(.CACHE_BYTES(8192)) DUT (.clk, .reset, .psel, .penable, .pwrite,
		.paddr, .pwdata, .prdata, .pready, .pslverr, .cr0_wr, .cr0_wr_data, .gp_fault,
		.gp_error_code, .line_fill_en, .write_through_en, .invalidate_en, .cache_flush_req,
		.cache_flush_done, .acc_valid, .acc_addr, .acc_isa, .acc_noncache, .acc_dma, .acc_done,
		.acc_cacheable, .acc_write_back, .acc_to_hidden_mgmt_memory, .acc_save_area, .acc_hidden_mgmt_memory_offset,
		.pmu_mgmt_req, .kbd_mgmt_req, .rsm_exec, .mgmt_interrupt, .mgmt_mode, .handler_entry_addr);
	flush_partner u_cache (.clk, .reset, .slow, .cache_flush_req, .cache_flush_done);
	function automatic logic [11:0] ra(input logic [7:0] i);
		return {2'b00, i, 2'b00};
	endfunction : ra
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			bad_count++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic cr0(input logic [31:0] d);
		@(posedge clk);
		cr0_wr <= 1'b1; cr0_wr_data <= d;
		@(posedge clk);
		cr0_wr <= 1'b0;
		#1;
	endtask : cr0
	task automatic acc(input logic [31:0] a, input logic [2:0] f);
		@(posedge clk);
		acc_valid <= 1'b1; acc_addr <= a; {acc_isa, acc_noncache, acc_dma} <= f;
		@(posedge clk);
		acc_valid <= 1'b0;
		#1;
		chk(acc_done, 1'b1);
	endtask : acc
	task automatic resume();
		apb(1'b1, ra(IDX_EVT_STATUS), 32'h3);
		@(posedge clk) rsm_exec <= 1'b1;
		@(posedge clk) rsm_exec <= 1'b0;
		#1 chk(mgmt_mode, 1'b0);
		repeat (4) @(posedge clk);
		#1 chk(mgmt_mode, 1'b0);
	endtask : resume
	task automatic t_reset();
		#1 chk({line_fill_en, write_through_en, invalidate_en}, 3'b111);
		chk(handler_entry_addr, 32'h0003_8000);
		apb(1'b0, ra(IDX_BASE_PTR), 32'h0);
		chk(rd, 32'h0003_0000);
		apb(1'b1, ra(8'hff), 32'hffff_ffff);
		chk(err, 1'b1);
		apb(1'b0, ra(8'hff), 32'h0);
		chk(rd, 32'h0);
		chk(err, 1'b1);
		apb(1'b0, ra(IDX_CACHE_MISC), 32'h0);
		chk(rd, 32'h0);
		chk(err, 1'b0);
	endtask : t_reset
	task automatic t_wb();
		acc(32'h0000_1000, 3'b000);
		chk({acc_cacheable, acc_write_back}, 2'b10);
		apb(1'b1, ra(IDX_CACHE_MISC), 32'h1);
		acc(32'h0000_1000, 3'b000);
		chk({acc_cacheable, acc_write_back}, 2'b11);
		acc(32'h0000_1000, 3'b100);
		chk({acc_cacheable, acc_write_back}, 2'b00);
		acc(32'h0000_1000, 3'b010);
		chk(acc_cacheable, 1'b0);
	endtask : t_wb
	task automatic t_modes();
		logic [1:0] m [4] = '{2'b11, 2'b10, 2'b01, 2'b00};
		logic [2:0] e [4] = '{3'b000, 3'b011, 3'b011, 3'b111};
		for (int k = 0; k < 4; k++) begin
			cr0({1'b0, m[k], 29'h0});
			chk(gp_fault, m[k] == 2'b01);
			chk(gp_error_code, 16'h0000);
			@(posedge clk);
			#1 chk({line_fill_en, write_through_en, invalidate_en}, e[k]);
			if (k == 2) begin
				apb(1'b0, ra(IDX_CR0_IMAGE), 32'h0);
				chk(rd, 32'h4000_0000);
			end
		end
	endtask : t_modes
	task automatic t_suppress();
		logic [31:0] o [5] = '{32'h8000, 32'hfe00, 32'hfdff, 32'h7fff, 32'h10000};
		logic [1:0]  e [5] = '{2'b10, 2'b11, 2'b10, 2'b00, 2'b00};
		apb(1'b1, ra(IDX_SMM_ATTR), 32'h20);
		@(posedge clk) pmu_mgmt_req <= 1'b1;
		@(posedge clk) pmu_mgmt_req <= 1'b0;
		repeat (6) @(posedge clk);
		#1 chk(mgmt_mode, 1'b0);
		apb(1'b1, ra(IDX_XMI_CTRL), 32'h1);
		for (int i = 0; i < 40 && mgmt_interrupt !== 1'b1; i++) @(negedge clk);
		chk({mgmt_interrupt, mgmt_mode, cache_flush_req}, 3'b110);
		for (int k = 0; k < 5; k++) begin
			acc(32'h0003_0000 + o[k], 3'b000);
			chk({acc_to_hidden_mgmt_memory, acc_save_area}, e[k]);
			if (e[k][1]) chk(acc_hidden_mgmt_memory_offset, o[k][14:0]);
		end
		resume();
	endtask : t_suppress
	task automatic t_flush();
		apb(1'b1, ra(IDX_SMM_ATTR), 32'h0);
		apb(1'b1, ra(IDX_BASE_PTR), 32'h000a_0000);
		slow <= 1'b1;
		@(posedge clk) kbd_mgmt_req <= 1'b1;
		@(posedge clk) kbd_mgmt_req <= 1'b0;
		for (int i = 0; i < 40 && cache_flush_req !== 1'b1; i++) @(posedge clk);
		repeat (3) @(posedge clk);
		#1 chk({cache_flush_req, mgmt_mode}, 2'b10);
		for (int i = 0; i < 40 && mgmt_interrupt !== 1'b1; i++) @(negedge clk);
		chk({mgmt_interrupt, mgmt_mode, cache_flush_req}, 3'b110);
		chk(handler_entry_addr, 32'h000a_8000);
		acc(32'h000a_fe00, 3'b000);
		chk({acc_to_hidden_mgmt_memory, acc_save_area}, 2'b11);
		resume();
	endtask : t_flush
	task automatic conclude();
		$display("checked=%0d bad_count=%0d", checked, bad_count);
		if (bad_count == 0 && checked > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : conclude
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	initial begin
		#40000;
		bad_count++;
		conclude();
	end
	initial begin
		{psel, penable, pwrite, cr0_wr, acc_valid, acc_isa, acc_noncache, acc_dma} = 8'h00;
		{pmu_mgmt_req, kbd_mgmt_req, rsm_exec, slow} = 4'h0;
		{paddr, pwdata, cr0_wr_data, acc_addr} = 108'h0;
		bad_count = 0;
		checked = 0;
		reset = 1'b1;
		repeat (20) @(posedge clk);
		reset <= 1'b0;
		@(posedge clk);
		t_reset();
		t_wb();
		t_modes();
		t_suppress();
		t_flush();
		conclude();
	end
endmodule : cache_mode_hidden_mgmt_memory_map_bench
`default_nettype wire
